// ---- rtl/rfe_map.vh ----
`ifndef RFE_MAP_VH
`define RFE_MAP_VH

// ****************************************
// Register addresses (7-bit)
// ****************************************
`define RFE_ADDR_MODE      7'h00
`define RFE_ADDR_RXCTL     7'h01
`define RFE_ADDR_SYNCSEL   7'h06
`define RFE_ADDR_REFDIV    7'h07
`define RFE_ADDR_FILTCLK   7'h08
`define RFE_ADDR_FEECTL    7'h15
`define RFE_ADDR_FEERES    7'h16

// ****************************************
// Reset values
// ****************************************
`define RFE_RST_MODE       8'h01
`define RFE_RST_RXCTL      8'h80
`define RFE_RST_SYNCSEL    8'h00
`define RFE_RST_REFDIV     8'h01
`define RFE_RST_FILTCLK    8'hc1
`define RFE_RST_FEECTL     8'h00

// ****************************************
// Read-back masks and fixed bits
// ****************************************
`define RFE_MASK_MODE      8'hfe
`define RFE_FIX_MODE       8'h01
`define RFE_MASK_RXCTL     8'h0f
`define RFE_FIX_RXCTL      8'h80
`define RFE_MASK_SYNCSEL   8'h0f
`define RFE_MASK_FILTCLK   8'h3f
`define RFE_FIX_FILTCLK    8'hc0
`define RFE_MASK_FEECTL    8'h0f

// ****************************************
// Field positions
// ****************************************
`define RFE_SYNC_EN_BIT    3
`define RFE_OPMODE_HI      2
`define RFE_OPMODE_LO      1
`define RFE_OPMODE_RX      2'h2
`define RFE_SHIFT_HI       3
`define RFE_SHIFT_LO       1
`define RFE_DIV_HI         5
`define RFE_DIV_LO         0
`define RFE_FEE_MODE_HI    1
`define RFE_FEE_MODE_LO    0
`define RFE_FEE_LEN_HI     3
`define RFE_FEE_LEN_LO     2

// ****************************************
// Estimator modes and lengths
// ****************************************
`define RFE_FEE_OFF        2'h0
`define RFE_FEE_UP         2'h1
`define RFE_FEE_DN         2'h2
`define RFE_FEE_BOTH       2'h3
`define RFE_FEE_MIN_SYMS   7'h08

// ****************************************
// Serial frame and bit synchroniser timing
// ****************************************
`define RFE_RW_BIT_IDX     5'h07
`define RFE_LAST_BIT_IDX   5'h0f
`define RFE_FRAME_BITS     5'h10
`define RFE_SHIFT_MAX      3'h7
`define RFE_PHASE_MID      4'h7
`define RFE_PHASE_HIGH_END 4'he
`define RFE_PHASE_LATE     4'h8

`endif

// ---- rtl/rfe_clkdiv.v ----
`default_nettype none

// Divides clk by a 6-bit ratio; ratio zero parks the divider.
module rfe_clkdiv (
  input  wire       clk,
  input  wire       rst,
  input  wire       ce,
  input  wire [5:0] ratio,
  output reg        tick,
  output reg        div_clk
);

  reg [5:0] cnt;

  always @(posedge clk) begin
    if (rst) begin
      cnt     <= 6'h00;
      tick    <= 1'b0;
      div_clk <= 1'b0;
    end else if (ce) begin
      if (ratio == 6'h00) begin
        cnt  <= 6'h00;
        tick <= 1'b0;
      end else if (cnt >= ratio - 6'h01) begin
        cnt     <= 6'h00;
        tick    <= 1'b1;
        div_clk <= ~div_clk;
      end else begin
        cnt  <= cnt + 6'h01;
        tick <= 1'b0;
      end
    end
  end

endmodule

`default_nettype wire

// ---- rtl/rfe_bitsync.v ----
`default_nettype none
`include "rfe_map.vh"

// Sixteen-times oversampling bit clock recovery
module rfe_bitsync (
  input  wire clk,
  input  wire rst,
  input  wire ce,
  input  wire enable,
  input  wire sample_tick,
  input  wire data_in,
  output reg  rec_clk,
  output reg  data_out,
  output reg  bit_strobe
);

  reg  [3:0] phase;
  reg  [3:0] next_phase;
  reg        prev_data;
  wire       edge_seen;

  assign edge_seen = data_in ^ prev_data;

  // bounded lock
  // One phase step per transition: worst offset of eight steps
  // is closed well inside the lock budget on preamble data.
  always @* begin
    next_phase = phase + 4'h1;
    if (edge_seen && phase != 4'h0) begin
      if (phase < `RFE_PHASE_LATE)
        next_phase = phase;
      else
        next_phase = phase + 4'h2;
    end
  end

  always @(posedge clk) begin
    if (rst) begin
      phase      <= 4'h0;
      prev_data  <= 1'b0;
      rec_clk    <= 1'b0;
      data_out   <= 1'b0;
      bit_strobe <= 1'b0;
    end else if (ce) begin
      bit_strobe <= 1'b0;
      if (!enable) begin
        rec_clk  <= 1'b0;
        data_out <= data_in;
      end
      if (sample_tick) begin
        phase     <= next_phase;
        prev_data <= data_in;
        // A phase held at mid must not resample the bit
        // data on rise
        if (next_phase == `RFE_PHASE_MID && phase != `RFE_PHASE_MID) begin
          bit_strobe <= 1'b1;
          if (enable)
            data_out <= data_in;
        end
        if (enable)
          rec_clk <= (next_phase >= `RFE_PHASE_MID) &&
                     (next_phase <= `RFE_PHASE_HIGH_END);
      end
    end
  end

endmodule

`default_nettype wire

// ---- rtl/rfe_rx_support.v ----
`default_nettype none
`include "rfe_map.vh"

module rfe_rx_support (
  input  wire       clk,
  input  wire       rst,
  input  wire       ce,
  input  wire       prog_clk,
  input  wire       prog_enable,
  input  wire       prog_data_in,
  output reg        prog_data_out,
  output reg        prog_data_oe,
  input  wire       up_pulse,
  input  wire       down_pulse,
  input  wire       demod_data,
  input  wire       main_filter_bypass,
  output reg        filter_clock,
  output reg        filter_bypass_sel,
  output reg        ref_clock_tick,
  output wire       recovered_clock_pin,
  output wire       serial_data_pin,
  output reg        serial_data_oe
);

  // ****************************************
  // Registers
  // ****************************************
  reg  [7:0] mode_reg;
  reg  [7:0] receiver_control;
  reg  [7:0] sync_clock_select;
  reg  [7:0] reference_divider_config;
  reg  [7:0] channel_filter_clock;
  reg  [7:0] freq_error_control;
  reg  [7:0] freq_error_estimate;

  wire [5:0] filter_clock_divider;
  wire [2:0] sync_shift_setting;
  wire [5:0] ref_div;
  wire [1:0] estimator_mode;
  wire [1:0] estimator_len;
  wire       rx_mode;
  wire       sync_active;

  assign filter_clock_divider = channel_filter_clock[`RFE_DIV_HI:`RFE_DIV_LO];
  assign sync_shift_setting = sync_clock_select[`RFE_SHIFT_HI:`RFE_SHIFT_LO];
  assign ref_div            = reference_divider_config[`RFE_DIV_HI:`RFE_DIV_LO];
  assign estimator_mode     = freq_error_control[`RFE_FEE_MODE_HI:`RFE_FEE_MODE_LO];
  assign estimator_len      = freq_error_control[`RFE_FEE_LEN_HI:`RFE_FEE_LEN_LO];
  assign rx_mode = (mode_reg[`RFE_OPMODE_HI:`RFE_OPMODE_LO] == `RFE_OPMODE_RX);
  assign sync_active = rx_mode && mode_reg[`RFE_SYNC_EN_BIT];

  // ****************************************
  // Serial programming interface
  // ****************************************
  reg        prog_clk_q;
  reg  [4:0] bit_cnt;
  reg  [15:0] frame;
  reg  [7:0] rd_shift;
  reg        rd_frame;
  reg        fee_start;
  wire       prog_rise;
  wire       prog_fall;
  wire [15:0] next_frame;
  wire [6:0] frame_addr;

  assign prog_rise  = prog_clk & ~prog_clk_q;
  assign prog_fall  = ~prog_clk & prog_clk_q;
  assign next_frame = {frame[14:0], prog_data_in};
  assign frame_addr = next_frame[15:9];

  function [7:0] read_value;
    input [6:0] addr;
    begin
      case (addr)
        `RFE_ADDR_MODE:
          read_value = (mode_reg & `RFE_MASK_MODE) | `RFE_FIX_MODE;
        `RFE_ADDR_RXCTL:
          read_value = (receiver_control & `RFE_MASK_RXCTL) | `RFE_FIX_RXCTL;
        `RFE_ADDR_SYNCSEL:
          read_value = sync_clock_select & `RFE_MASK_SYNCSEL;
        `RFE_ADDR_REFDIV:
          read_value = reference_divider_config;
        `RFE_ADDR_FILTCLK:
          read_value = (channel_filter_clock & `RFE_MASK_FILTCLK) | `RFE_FIX_FILTCLK;
        `RFE_ADDR_FEECTL:
          read_value = freq_error_control & `RFE_MASK_FEECTL;
        `RFE_ADDR_FEERES:
          read_value = freq_error_estimate;
        default:
          read_value = 8'h00;
      endcase
    end
  endfunction

  always @(posedge clk) begin
    if (rst) begin
      prog_clk_q               <= 1'b0;
      bit_cnt                  <= 5'h00;
      frame                    <= 16'h0000;
      rd_shift                 <= 8'h00;
      rd_frame                 <= 1'b0;
      prog_data_out            <= 1'b0;
      prog_data_oe             <= 1'b0;
      fee_start                <= 1'b0;
      mode_reg                 <= `RFE_RST_MODE;
      receiver_control         <= `RFE_RST_RXCTL;
      sync_clock_select        <= `RFE_RST_SYNCSEL;
      reference_divider_config <= `RFE_RST_REFDIV;
      channel_filter_clock     <= `RFE_RST_FILTCLK;
      freq_error_control       <= `RFE_RST_FEECTL;
    end else if (ce) begin
      prog_clk_q <= prog_clk;
      fee_start  <= 1'b0;
      if (!prog_enable) begin
        // Frame aborted or ended: release the data pin
        bit_cnt      <= 5'h00;
        rd_frame     <= 1'b0;
        prog_data_oe <= 1'b0;
      end else begin
        if (prog_rise && bit_cnt < `RFE_FRAME_BITS) begin
          frame   <= next_frame;
          bit_cnt <= bit_cnt + 5'h01;
          if (bit_cnt == `RFE_RW_BIT_IDX && prog_data_in) begin
            rd_frame <= 1'b1;
            rd_shift <= read_value(next_frame[7:1]);
          end
          if (bit_cnt == `RFE_LAST_BIT_IDX && !rd_frame) begin
            case (frame_addr)
              `RFE_ADDR_MODE:    mode_reg          <= next_frame[7:0];
              `RFE_ADDR_RXCTL:   receiver_control  <= next_frame[7:0];
              `RFE_ADDR_SYNCSEL: sync_clock_select <= next_frame[7:0];
              `RFE_ADDR_REFDIV:  reference_divider_config <= next_frame[7:0];
              `RFE_ADDR_FILTCLK: channel_filter_clock <= next_frame[7:0];
              `RFE_ADDR_FEECTL: begin
                freq_error_control <= next_frame[7:0];
                fee_start          <= 1'b1;
              end
              default: ;
            endcase
          end
        end
        // Read data changes on the falling edge so the host can
        // take it on the next rising edge
        if (prog_fall && rd_frame) begin
          if (bit_cnt < `RFE_FRAME_BITS) begin
            prog_data_out <= rd_shift[7];
            rd_shift      <= {rd_shift[6:0], 1'b0};
            prog_data_oe  <= 1'b1;
          end else begin
            prog_data_oe <= 1'b0;
          end
        end
      end
    end
  end

  // ****************************************
  // Channel filter clock
  // ****************************************
  wire filt_div_clk;

  // toggle per ratio gives twenty times cutoff
  rfe_clkdiv u_filter_div (
    .clk     (clk),
    .rst     (rst),
    .ce      (ce),
    .ratio   (filter_clock_divider),
    .tick    (),
    .div_clk (filt_div_clk)
  );

  always @(posedge clk) begin
    if (rst) begin
      filter_clock      <= 1'b0;
      filter_bypass_sel <= 1'b0;
    end else if (ce) begin
      // bypass route
      // Clock is parked while bypassed to save receive current
      filter_bypass_sel <= main_filter_bypass;
      filter_clock      <= main_filter_bypass ? 1'b0 : filt_div_clk;
    end
  end

  // ****************************************
  // Reference and bit synchroniser clocks
  // ****************************************
  wire       ref_tick;
  reg  [6:0] pre_cnt;
  reg        sample_tick;
  wire [7:0] pre_full;
  wire [6:0] pre_limit;

  // divider 1 to 63; zero stops it
  rfe_clkdiv u_ref_div (
    .clk     (clk),
    .rst     (rst),
    .ce      (ce),
    .ratio   (ref_div),
    .tick    (ref_tick),
    .div_clk ()
  );

  // two to the seven minus shift
  assign pre_full  = 8'h01 << (`RFE_SHIFT_MAX - sync_shift_setting);
  assign pre_limit = pre_full[6:0] - 7'h01;

  always @(posedge clk) begin
    if (rst) begin
      pre_cnt        <= 7'h00;
      sample_tick    <= 1'b0;
      ref_clock_tick <= 1'b0;
    end else if (ce) begin
      ref_clock_tick <= ref_tick;
      sample_tick    <= 1'b0;
      if (ref_tick) begin
        if (pre_cnt >= pre_limit) begin
          pre_cnt     <= 7'h00;
          sample_tick <= 1'b1;
        end else begin
          pre_cnt <= pre_cnt + 7'h01;
        end
      end
    end
  end

  wire bit_strobe;

  rfe_bitsync u_bitsync (
    .clk         (clk),
    .rst         (rst),
    .ce          (ce),
    .enable      (sync_active),
    .sample_tick (sample_tick),
    .data_in     (demod_data),
    .rec_clk     (recovered_clock_pin),
    .data_out    (serial_data_pin),
    .bit_strobe  (bit_strobe)
  );

  always @(posedge clk) begin
    if (rst)
      serial_data_oe <= 1'b0;
    else if (ce)
      serial_data_oe <= rx_mode;
  end

  // ****************************************
  // Frequency error estimator
  // ****************************************
  localparam ST_IDLE = 2'd0;
  localparam ST_RUN  = 2'd1;
  localparam ST_HOLD = 2'd2;

  reg  [1:0] est_state;
  reg  [6:0] sym_cnt;
  reg  [7:0] delta;
  wire [6:0] sym_total;
  wire       count_up;
  wire       count_dn;

  assign sym_total = `RFE_FEE_MIN_SYMS << estimator_len;
  assign count_up = up_pulse &&
                    (estimator_mode == `RFE_FEE_UP || estimator_mode == `RFE_FEE_BOTH);
  assign count_dn = down_pulse &&
                    (estimator_mode == `RFE_FEE_DN || estimator_mode == `RFE_FEE_BOTH);

  // down steps subtract in two's complement
  always @* begin
    delta = 8'h00;
    if (count_up && !count_dn)
      delta = 8'h01;
    else if (count_dn && !count_up)
      delta = 8'hff;
  end

  always @(posedge clk) begin
    if (rst) begin
      est_state           <= ST_IDLE;
      sym_cnt             <= 7'h00;
      freq_error_estimate <= 8'h00;
    end else if (ce) begin
      if (fee_start) begin
        freq_error_estimate <= 8'h00;
        sym_cnt             <= 7'h00;
        est_state <= (freq_error_control[`RFE_FEE_MODE_HI:`RFE_FEE_MODE_LO] ==
                      `RFE_FEE_OFF) ? ST_IDLE : ST_RUN;
      end else begin
        case (est_state)
          ST_RUN: begin
            freq_error_estimate <= freq_error_estimate + delta;
            if (bit_strobe) begin
              sym_cnt <= sym_cnt + 7'h01;
              if (sym_cnt == sym_total - 7'h01)
                est_state <= ST_HOLD;
            end
          end
          ST_HOLD: est_state <= ST_HOLD;
          ST_IDLE: est_state <= ST_IDLE;
          default: est_state <= ST_IDLE;
        endcase
      end
    end
  end

endmodule

`default_nettype wire

// ---- testbench/rfe_rx_assertions.sv ----
`default_nettype none
module rfe_rx_chk (
  input wire logic clk,
  input wire logic rst,
  input wire logic prog_clk,
  input wire logic prog_enable,
  input wire logic prog_data_oe,
  input wire logic main_filter_bypass,
  input wire logic filter_clock,
  input wire logic filter_bypass_sel,
  input wire logic recovered_clock_pin,
  input wire logic serial_data_pin,
  input wire logic serial_data_oe
);
  timeunit 1ns;
  timeprecision 1ps;
  // ******************
  // Port relations
  // ******************
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  chk_bypass_gate: assert property (
    main_filter_bypass [*3] |=> !filter_clock) else $error("filter clock runs in bypass");
  chk_bypass_copy: assert property (
    !$past(rst) |-> filter_bypass_sel == $past(main_filter_bypass))
    else $error("bypass select lags wrongly");
  chk_clock_rx_only: assert property (
    recovered_clock_pin |-> serial_data_oe) else $error("bit clock outside receive");
  chk_clock_high_len: assert property (
    $rose(recovered_clock_pin) |-> recovered_clock_pin [*6]) else $error("bit clock high short");
  chk_clock_low_len: assert property (
    $fell(recovered_clock_pin) |-> !recovered_clock_pin [*6]) else $error("bit clock low short");
  chk_data_on_rise: assert property (
    recovered_clock_pin && $past(recovered_clock_pin) |-> $stable(serial_data_pin))
    else $error("data moved while clock high");
  chk_oe_release: assert property (
    !prog_enable && !$past(prog_enable) |-> !prog_data_oe) else $error("read drive held");
  chk_oe_start: assert property (
    $rose(prog_data_oe) |-> prog_enable && !prog_clk) else $error("read drive began late");
  cover property ($rose(recovered_clock_pin));
  cover property ($rose(prog_data_oe));
  cover property (main_filter_bypass [*3]);
  cover property ($rose(filter_clock));
endmodule

bind rfe_rx_support rfe_rx_chk chk_u (
  .clk(clk), .rst(rst), .prog_clk(prog_clk), .prog_enable(prog_enable),
  .prog_data_oe(prog_data_oe), .main_filter_bypass(main_filter_bypass),
  .filter_clock(filter_clock), .filter_bypass_sel(filter_bypass_sel),
  .recovered_clock_pin(recovered_clock_pin), .serial_data_pin(serial_data_pin),
  .serial_data_oe(serial_data_oe)
);
`default_nettype wire

// ---- testbench/rfe_host_model.sv ----
`default_nettype none
module rfe_host_model (
  input wire logic recovered_clock_pin,
  input wire logic serial_data_pin
);
  timeunit 1ns;
  timeprecision 1ps;
  bit got[$];
  // ******************
  // Host sampling
  // ******************
  // sample on fall
  always @(negedge recovered_clock_pin) begin
    got.push_back(serial_data_pin);
  end
endmodule
`default_nettype wire

// ---- testbench/testbench.sv ----
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        pclk = 1'b0;
  logic        pen = 1'b0;
  logic        pdi = 1'b0;
  logic        up = 1'b0;
  logic        dn = 1'b0;
  logic        dd = 1'b0;
  logic        byp = 1'b0;
  logic        ce = 1'b1;
  wire logic   pdo, poe, fclk, bsel, rtick, rclk, sdat, soe;
  int          n_errors = 0;
  int          total_checks = 0;
  int          e;
  int          tg;
  bit          ok;
  bit          sent[$];
  logic [7:0]  q;
  logic [31:0] seed = 32'h67fee7bc;
  logic [31:0] r;
  logic [6:0]  ra [8] = '{7'h00, 7'h01, 7'h06, 7'h07, 7'h08, 7'h15, 7'h16, 7'h30};
  logic [7:0]  rv [8] = '{8'h01, 8'h80, 8'h00, 8'h01, 8'hc1, 8'h00, 8'h00, 8'h00};
  int          dv [3] = '{1, 3, 63};

  always #5 clk = ~clk;

  rfe_rx_support dut_u (
    .clk(clk), .rst(rst), .ce(ce), .prog_clk(pclk), .prog_enable(pen),
    .prog_data_in(pdi), .prog_data_out(pdo), .prog_data_oe(poe), .up_pulse(up),
    .down_pulse(dn), .demod_data(dd), .main_filter_bypass(byp), .filter_clock(fclk),
    .filter_bypass_sel(bsel), .ref_clock_tick(rtick), .recovered_clock_pin(rclk),
    .serial_data_pin(sdat), .serial_data_oe(soe)
  );
  rfe_host_model host_u (.recovered_clock_pin(rclk), .serial_data_pin(sdat));

  // ******************
  // Tasks
  // ******************
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic summarize();
    $display("checks=%0d errors=%0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  // Slow edges: the port samples the programming clock in the clk domain
  task automatic frame(input logic [6:0] a, input logic rd, input logic [7:0] wd);
    logic [15:0] w;
    w = {a, rd, wd};
    pen = 1'b1;
    for (int i = 15; i >= 0; i--) begin
      pdi = w[i];
      step(2);
      pclk = 1'b1;
      step(3);
      if (i < 8) q[i] = pdo;
      pclk = 1'b0;
      step(3);
    end
    pen = 1'b0;
    step(2);
  endtask

  task automatic rd(input logic [6:0] a, input logic [7:0] exp);
    frame(a, 1'b1, 8'h00);
    cmp(q, exp);
  endtask

  task automatic tog(input int n);
    logic p;
    tg = 0;
    p = fclk;
    repeat (n) begin
      step(1);
      tg += int'(fclk !== p);
      p = fclk;
    end
  endtask

  // Pulses only inside windows whose fate is certain for every length
  task automatic fee(input logic [3:0] ctl, input bit dense);
    int ns;
    bit u, d, act, cnt;
    r = rnd();
    frame(7'h15, 1'b0, {r[7:4], ctl});
    ns = 8 << ctl[3:2];
    e = 0;
    for (int c = 0; c < 230; c++) begin
      r = rnd();
      act = c < 100 || (dense && c < 140) || (c >= 160 && c < 220);
      cnt = c < 100 || (dense && c < 140) || (c >= 160 && c < 220 && ns >= 16);
      u = act && !dense && r[0];
      d = act && (dense || r[1]);
      up = u;
      dn = d;
      if (cnt) e += int'(ctl[0] & u) - int'(ctl[1] & d);
      step(1);
    end
    up = 1'b0;
    dn = 1'b0;
    step(1100);
    repeat (20) begin
      r = rnd();
      up = r[0];
      dn = r[1];
      step(1);
    end
    up = 1'b0;
    dn = 1'b0;
    rd(7'h15, {4'h0, ctl});
    rd(7'h16, e[7:0]);
  endtask

  task automatic sync(input int bl);
    int n;
    host_u.got.delete();
    sent.delete();
    repeat (60) begin
      r = rnd();
      dd = r[0];
      sent.push_back(r[0]);
      step(bl);
    end
    n = host_u.got.size();
    ok = 1'b0;
    for (int s = 0; s < 4; s++) begin
      int bad;
      bad = int'(n < 34);
      for (int j = 0; j < 34 && n >= 34; j++) bad += int'(host_u.got[n-1-j] != sent[59-j-s]);
      if (bad == 0) ok = 1'b1;
    end
    cmp({7'h00, ok}, 8'h01);
  endtask

  // ******************
  // Sequence
  // ******************
  initial begin
    repeat (100000) @(posedge clk);
    n_errors++;
    summarize();
  end

  initial begin
    step(16);
    rst = 1'b0;
    step(1);
    cmp({7'h00, soe}, 8'h00);
    for (int k = 0; k < 8; k++) rd(ra[k], rv[k]);
    frame(7'h16, 1'b0, 8'h55);
    rd(7'h16, 8'h00);
    frame(7'h06, 1'b0, 8'hff);
    rd(7'h06, 8'h0f);
    // Clock enable low must freeze the divided clock
    ce = 1'b0;
    tog(40);
    cmp(tg[7:0], 8'h00);
    ce = 1'b1;
    tog(40);
    cmp(tg[7:0], 8'h28);
    foreach (dv[k]) begin
      frame(7'h08, 1'b0, {2'b00, dv[k][5:0]});
      rd(7'h08, {2'b11, dv[k][5:0]});
      tog(126);
      cmp(tg[7:0], 8'(126 / dv[k]));
    end
    byp = 1'b1;
    step(3);
    tog(40);
    cmp({bsel, tg[6:0]}, 8'h80);
    byp = 1'b0;
    frame(7'h06, 1'b0, 8'h0e);
    for (int k = 0; k < 16; k++) fee(k[3:0], 1'b0);
    fee(4'he, 1'b1);
    frame(7'h00, 1'b0, 8'h05);
    cmp({7'h00, soe}, 8'h01);
    repeat (20) begin
      r = rnd();
      dd = r[0];
      step(1);
      cmp({6'h00, rclk, sdat}, {7'h00, r[0]});
    end
    frame(7'h00, 1'b0, 8'h0d);
    sync(16);
    frame(7'h07, 1'b0, 8'h03);
    frame(7'h06, 1'b0, 8'h0c);
    tg = 0;
    repeat (30) begin
      step(1);
      tg += int'(rtick === 1'b1);
    end
    cmp(tg[7:0], 8'h0a);
    sync(96);
    summarize();
  end
endmodule
`default_nettype wire
